// ===== design/twbr_target.sv
// Two-wire target interface with pointer register, general call and broadcast access
`timescale 1ns/1ps
module twbr_target #(
    parameter logic [2:0] VARIANT        = 3'h0,
    parameter int         TIMEOUT_CYCLES = twbr_pkg::TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Two-wire pins; clock line is input only
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Register side
    input  wire logic [7:0] read_data,
    output logic [1:0]      register_select_bits,
    output logic [7:0]      write_data,
    output logic            write_strobe,
    output logic            general_reset,
    output logic            hs_filter
);

    // ------------------------------------------------------------
    // Reset release and line front end
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    twbr_line_if lines ();

    twbr_line_front u_front (
        .clk    (clk),
        .rst_n  (rst_n),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .lines  (lines.front)
    );

    // ------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------
    twbr_pkg::twbr_state_type state_q, state_d;
    logic [7:0]  shift_q, shift_d;
    logic [3:0]  bit_q, bit_d;
    logic [1:0]  rx_idx_q, rx_idx_d;       // 0 pointer/command, 1 data
    logic        is_gcall_q, is_gcall_d;
    logic        is_bcast_q, is_bcast_d;
    logic        ack_drive_q, ack_drive_d;
    logic        tx_mine_q, tx_mine_d;     // This slot carries our byte
    logic [2:0]  slot_q, slot_d;
    logic [7:0]  pointer_q, pointer_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        wstrobe_q, wstrobe_d;
    logic        greset_q, greset_d;
    logic        hs_q, hs_d;
    logic        sda_low_q, sda_low_d;
    logic [31:0] tmo_q, tmo_d;
    logic        timeout;
    logic [7:0]  rx_byte;
    logic        own_match;

    assign timeout   = (tmo_q >= 32'(TIMEOUT_CYCLES));
    assign rx_byte   = {shift_q[6:0], lines.sda_level};
    assign own_match = (rx_byte[7:1] == (twbr_pkg::OWN_ADDR_BASE | {4'h0, VARIANT}));

    // Next-state logic: sampling on rising SCL, driving on falling SCL
    always_comb begin
        state_d     = state_q;
        shift_d     = shift_q;
        bit_d       = bit_q;
        rx_idx_d    = rx_idx_q;
        is_gcall_d  = is_gcall_q;
        is_bcast_d  = is_bcast_q;
        ack_drive_d = ack_drive_q;
        tx_mine_d   = tx_mine_q;
        slot_d      = slot_q;
        pointer_d   = pointer_q;
        wdata_d     = wdata_q;
        wstrobe_d   = 1'b0;
        greset_d    = 1'b0;
        hs_d        = hs_q;
        sda_low_d   = sda_low_q;
        tmo_d       = (lines.scl_level || state_q == twbr_pkg::TWBR_IDLE) ? 32'h0 : tmo_q + 32'h1;

        if (timeout) begin
            state_d   = twbr_pkg::TWBR_IDLE;
            sda_low_d = 1'b0;
            tmo_d     = 32'h0;
        end else if (lines.stop_det) begin
            state_d   = twbr_pkg::TWBR_IDLE;
            sda_low_d = 1'b0;
            hs_d      = 1'b0;
        end else if (lines.start_det) begin
            state_d   = twbr_pkg::TWBR_ADDR;
            bit_d     = twbr_pkg::BIT_ZERO;
            sda_low_d = 1'b0;
        end else begin
            case (state_q)
                twbr_pkg::TWBR_IDLE, twbr_pkg::TWBR_IGNORE: begin
                    sda_low_d = 1'b0;
                end
                twbr_pkg::TWBR_ADDR: begin
                    if (lines.scl_rise) begin
                        shift_d = rx_byte;
                        bit_d   = bit_q + 4'h1;
                        if (bit_q == twbr_pkg::BIT_LAST) begin
                            rx_idx_d   = 2'h0;
                            slot_d     = 3'h0;
                            is_gcall_d = (rx_byte == twbr_pkg::BCAST_WR_BYTE);
                            is_bcast_d = (rx_byte == twbr_pkg::BCAST_RD_BYTE);
                            tx_mine_d  = (rx_byte == twbr_pkg::BCAST_RD_BYTE) ? (VARIANT == 3'h0) : 1'b1;
                            if (rx_byte[7:3] == twbr_pkg::HS_CODE_PREFIX) begin
                                hs_d    = 1'b1;
                                state_d = twbr_pkg::TWBR_IGNORE;
                            end else if (own_match || rx_byte == twbr_pkg::BCAST_WR_BYTE
                                         || rx_byte == twbr_pkg::BCAST_RD_BYTE) begin
                                ack_drive_d = 1'b1;
                                state_d     = twbr_pkg::TWBR_ACK;
                            end else begin
                                state_d = twbr_pkg::TWBR_IGNORE;
                            end
                        end
                    end
                end
                twbr_pkg::TWBR_RXBYTE: begin
                    if (lines.scl_fall) begin
                        sda_low_d = 1'b0;
                    end
                    if (lines.scl_rise) begin
                        shift_d = rx_byte;
                        bit_d   = bit_q + 4'h1;
                        if (bit_q == twbr_pkg::BIT_LAST) begin
                            ack_drive_d = 1'b1;
                            state_d     = twbr_pkg::TWBR_ACK;
                            if (rx_idx_q == 2'h0) begin
                                // Broadcast write byte doubles as general call
                                if (is_gcall_q && rx_byte == twbr_pkg::GCALL_RESET_CMD) begin
                                    greset_d  = 1'b1;
                                    pointer_d = twbr_pkg::POINTER_RESET;
                                end else begin
                                    pointer_d = rx_byte;
                                end
                                rx_idx_d = 2'h1;
                            end else if (rx_idx_q == 2'h1) begin
                                // Whole byte in before anything is written; the read-only
                                // slot is acknowledged but leaves write_data untouched
                                if (pointer_q[1:0] != twbr_pkg::SEL_TEMP) begin
                                    wdata_d   = rx_byte;
                                    wstrobe_d = 1'b1;
                                end
                                rx_idx_d  = 2'h2;
                            end else begin
                                ack_drive_d = 1'b0;
                                state_d     = twbr_pkg::TWBR_IGNORE;
                            end
                        end
                    end
                end
                twbr_pkg::TWBR_ACK: begin
                    if (lines.scl_fall) begin
                        if (ack_drive_q) begin
                            sda_low_d   = 1'b1;
                            ack_drive_d = 1'b0;
                        end else begin
                            sda_low_d = 1'b0;
                            bit_d     = twbr_pkg::BIT_ZERO;
                            if (shift_q[0] && rx_idx_q == 2'h0 && !ack_drive_q && state_q == twbr_pkg::TWBR_ACK
                                && (slot_q == 3'h0) && bit_q != twbr_pkg::BIT_ZERO) begin
                                // Read: first data bit goes out now
                                state_d   = twbr_pkg::TWBR_TXBYTE;
                                shift_d   = read_data;
                                sda_low_d = tx_mine_q & ~read_data[7];
                                bit_d     = 4'h1;
                            end else begin
                                state_d = twbr_pkg::TWBR_RXBYTE;
                            end
                        end
                    end
                end
                twbr_pkg::TWBR_TXBYTE: begin
                    if (lines.scl_fall) begin
                        if (bit_q == 4'h8) begin
                            sda_low_d = 1'b0;
                            state_d   = twbr_pkg::TWBR_TXACK;
                        end else begin
                            sda_low_d = tx_mine_q & ~shift_q[3'(4'h7 - bit_q)];
                            bit_d     = bit_q + 4'h1;
                        end
                    end
                end
                twbr_pkg::TWBR_TXACK: begin
                    if (lines.scl_rise) begin
                        if (lines.sda_level || !is_bcast_q || slot_q == VARIANT) begin
                            state_d = twbr_pkg::TWBR_IGNORE;
                        end else begin
                            slot_d    = slot_q + 3'h1;
                            tx_mine_d = ((slot_q + 3'h1) == VARIANT);
                        end
                    end else if (lines.scl_fall) begin
                        state_d   = twbr_pkg::TWBR_TXBYTE;
                        shift_d   = read_data;
                        sda_low_d = tx_mine_q & ~read_data[7];
                        bit_d     = 4'h1;
                    end
                end
                default: begin
                    state_d   = twbr_pkg::TWBR_IDLE;
                    sda_low_d = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= twbr_pkg::TWBR_IDLE;
            shift_q     <= 8'h00;
            bit_q       <= 4'h0;
            rx_idx_q    <= 2'h0;
            is_gcall_q  <= 1'b0;
            is_bcast_q  <= 1'b0;
            ack_drive_q <= 1'b0;
            tx_mine_q   <= 1'b0;
            slot_q      <= 3'h0;
            pointer_q   <= twbr_pkg::POINTER_RESET;
            wdata_q     <= 8'h00;
            wstrobe_q   <= 1'b0;
            greset_q    <= 1'b0;
            hs_q        <= 1'b0;
            sda_low_q   <= 1'b0;
            tmo_q       <= 32'h0;
        end else begin
            state_q     <= state_d;
            shift_q     <= shift_d;
            bit_q       <= bit_d;
            rx_idx_q    <= rx_idx_d;
            is_gcall_q  <= is_gcall_d;
            is_bcast_q  <= is_bcast_d;
            ack_drive_q <= ack_drive_d;
            tx_mine_q   <= tx_mine_d;
            slot_q      <= slot_d;
            pointer_q   <= pointer_d;
            wdata_q     <= wdata_d;
            wstrobe_q   <= wstrobe_d;
            greset_q    <= greset_d;
            hs_q        <= hs_d;
            sda_low_q   <= sda_low_d;
            tmo_q       <= tmo_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs; the clock line has no driver at all
    // ------------------------------------------------------------
    assign lines.hs_mode        = hs_q;
    assign hs_filter            = hs_q;
    assign sda_out              = 1'b0;
    assign sda_oe_n             = ~sda_low_q;
    assign register_select_bits = pointer_q[1:0];
    assign write_data           = wdata_q;
    assign write_strobe         = wstrobe_q;
    assign general_reset        = greset_q;

endmodule : twbr_target

// ===== design/twbr_pkg.sv
// Package of constants for the two-wire target interface with broadcast access
package twbr_pkg;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [6:0] OWN_ADDR_BASE   = 7'h70;  // 1110000, variant adds 0..7
    localparam logic [6:0] GCALL_ADDR      = 7'h00;  // General call, write only
    localparam logic [7:0] BCAST_WR_BYTE   = 8'h00;  // Broadcast write address byte
    localparam logic [7:0] BCAST_RD_BYTE   = 8'h01;  // Broadcast read address byte
    localparam logic [4:0] HS_CODE_PREFIX  = 5'h01;  // 00001xxx master code
    localparam logic [7:0] GCALL_RESET_CMD = 8'h06;  // General-call reset command

    // ------------------------------------------------------------
    // Pointer and register select
    // ------------------------------------------------------------
    localparam logic [7:0] POINTER_RESET   = 8'h00;
    localparam logic [1:0] SEL_TEMP        = 2'h0;  // Read only
    localparam logic [1:0] SEL_CONFIG      = 2'h1;
    localparam logic [1:0] SEL_LOW_LIMIT   = 2'h2;
    localparam logic [1:0] SEL_HIGH_LIMIT  = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int TIMEOUT_MS       = 30;
    localparam int TIMEOUT_CYCLES   = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Byte bit counter
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h7;  // Index of eighth bit in a byte
    localparam logic [3:0] BIT_ZERO = 4'h0;

    // Controller states, one-hot
    typedef enum logic [6:0] {
        TWBR_IDLE    = 7'h01,  // Waiting for START
        TWBR_ADDR    = 7'h02,  // Shifting address byte
        TWBR_RXBYTE  = 7'h04,  // Shifting pointer, data or command byte
        TWBR_ACK     = 7'h08,  // Driving acknowledge
        TWBR_TXBYTE  = 7'h10,  // Shifting out a data byte
        TWBR_TXACK   = 7'h20,  // Sampling controller acknowledge
        TWBR_IGNORE  = 7'h40   // Not addressed, wait for START or STOP
    } twbr_state_type;

endpackage : twbr_pkg

// ===== design/twbr_line_if.sv
// Interface carrying sampled line events from the front end to the controller
`timescale 1ns/1ps
interface twbr_line_if;
    logic scl_rise;
    logic scl_fall;
    logic scl_level;
    logic sda_level;
    logic start_det;
    logic stop_det;
    logic hs_mode;

    modport front (output scl_rise, output scl_fall, output scl_level, output sda_level,
                   output start_det, output stop_det, input hs_mode);
    modport core  (input scl_rise, input scl_fall, input scl_level, input sda_level,
                   input start_det, input stop_det, output hs_mode);
endinterface : twbr_line_if

// ===== design/twbr_line_front.sv
// Synchronisers and START/STOP/edge detection for the two wires
`timescale 1ns/1ps
module twbr_line_front (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Raw pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Events towards the controller
    twbr_line_if.front lines
);

    logic [1:0] scl_sync_q, scl_sync_d;
    logic [1:0] sda_sync_q, sda_sync_d;
    logic       scl_prev_q, scl_prev_d;
    logic       sda_prev_q, sda_prev_d;

    // ------------------------------------------------------------
    // Two-stage sync, then one history stage for edges
    // ------------------------------------------------------------
    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_in};
        sda_sync_d = {sda_sync_q[0], sda_in};
        scl_prev_d = scl_sync_q[1];
        sda_prev_d = sda_sync_q[1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    // Only the second stage and the history stage are examined; SDA moves with SCL high mark conditions
    assign lines.scl_level = scl_sync_q[1];
    assign lines.sda_level = sda_sync_q[1];
    assign lines.scl_rise  = scl_sync_q[1] & ~scl_prev_q;
    assign lines.scl_fall  = ~scl_sync_q[1] & scl_prev_q;
    assign lines.start_det = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign lines.stop_det  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

endmodule : twbr_line_front

// ===== verif/twbr_target_asserts.sv
// Concurrent checks on the ports of the two-wire target
`timescale 1ns/1ps
module twbr_target_asserts #(
    parameter int TIMEOUT_CYCLES = 200
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Two-wire pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    // Register side
    input wire logic [7:0] read_data,
    input wire logic [1:0] register_select_bits,
    input wire logic [7:0] write_data,
    input wire logic       write_strobe,
    input wire logic       general_reset,
    input wire logic       hs_filter
);
    // ------------------------------------------------------------
    // Helper logic and checks
    // ------------------------------------------------------------
    int scl_low_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Cycles of SCL low; saturates so it never wraps on a parked bus
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_low_q <= 0;
        end else if (scl_in) begin
            scl_low_q <= 0;
        end else if (scl_low_q < TIMEOUT_CYCLES + 20) begin
            scl_low_q <= scl_low_q + 1;
        end
    end

    // Data line released for eight cycles in a row
    sequence released_8;
        sda_oe_n [*8];
    endsequence

    chk_pin_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out not held at zero");
    chk_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while SCL high");
    chk_strobe_pulse: assert property (write_strobe |=> !write_strobe)
        else $error("write_strobe longer than one cycle");
    chk_strobe_not_temp: assert property (write_strobe |-> register_select_bits != twbr_pkg::SEL_TEMP)
        else $error("write strobe to read-only register");
    chk_wdata_on_strobe: assert property ($changed(write_data) |->
        write_strobe || $past(write_strobe) || general_reset || $past(general_reset))
        else $error("write_data changed without a strobe");
    chk_greset_pointer: assert property (general_reset |-> ##[0:3] register_select_bits == 2'h0)
        else $error("pointer not cleared by general reset");
    chk_greset_pulse: assert property (general_reset |=> !general_reset)
        else $error("general_reset longer than one cycle");
    chk_hs_no_ack: assert property ($rose(hs_filter) |->
        released_8 ##1 released_8 ##1 released_8 ##1 released_8)
        else $error("master code acknowledged");
    chk_hs_until_stop: assert property ($fell(hs_filter) |-> scl_in && sda_in)
        else $error("high-speed filter dropped without STOP");
    chk_timeout_release: assert property (scl_low_q >= TIMEOUT_CYCLES + 10 |-> sda_oe_n)
        else $error("data line held after SCL low timeout");
endmodule : twbr_target_asserts

bind twbr_target twbr_target_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .read_data(read_data), .register_select_bits(register_select_bits),
    .write_data(write_data), .write_strobe(write_strobe), .general_reset(general_reset),
    .hs_filter(hs_filter)
);

// ===== verif/twbr_ctrl_model.sv
// Behavioural two-wire bus controller that drives the target's link
`timescale 1ns/1ps
module twbr_ctrl_model (
    // Pacing clock
    input  wire logic clk,
    // Bus lines, 1 on an output means released
    input  wire logic sda_in,
    output logic      scl_o,
    output logic      sda_o
);
    // ------------------------------------------------------------
    // Bus conditions and bits
    // ------------------------------------------------------------
    // Idle bus: clock stands still high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Quarter of a 160 ns SCL period, changes land on falling clk edges
    task automatic quarter;
        repeat (4) @(negedge clk);
    endtask : quarter

    // START or repeated START, data falls while the clock is high
    task automatic start;
        sda_o = 1'b1;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_o = 1'b0;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask : start

    // STOP, plus bus free time so the target sees the idle bus
    task automatic stop;
        sda_o = 1'b0;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_o = 1'b1;
        quarter();
        quarter();
    endtask : stop

    // One bit: data only changes while the clock is low
    task automatic bit_x(input logic b, output logic s);
        sda_o = b;
        quarter();
        scl_o = 1'b1;
        quarter();
        s = sda_in;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask : bit_x

    // Eight bits then the ninth acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ack_bit, ack);
    endtask : xfer
endmodule : twbr_ctrl_model

// ===== verif/twbr_target_test.sv
// Self-checking bench for the two-wire target
`timescale 1ns/1ps
module twbr_target_test;
    // ------------------------------------------------------------
    // Wiring, tasks and tests
    // ------------------------------------------------------------
    localparam logic [2:0] VAR   = 3'h2;
    localparam int         TMO   = 200;
    localparam logic [7:0] OWN_W = {twbr_pkg::OWN_ADDR_BASE + 7'(VAR), 1'b0};
    localparam logic [7:0] OWN_R = OWN_W | 8'h01;
    logic       clk;
    logic       resetn;
    logic [7:0] read_data;
    logic       scl;
    logic       ctl_sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic [1:0] register_select_bits;
    logic [7:0] write_data;
    logic       write_strobe;
    logic       general_reset;
    logic       hs_filter;
    int         n_fail;
    int         compares;
    int         n_strobe;
    int         n_greset;
    int         cycles;
    // Open-drain data line with pull-up
    wire        sda = ctl_sda & (sda_oe_n | sda_out);

    twbr_target #(.VARIANT(VAR), .TIMEOUT_CYCLES(TMO)) uut (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .read_data(read_data), .register_select_bits(register_select_bits), .write_data(write_data),
        .write_strobe(write_strobe), .general_reset(general_reset), .hs_filter(hs_filter)
    );
    twbr_ctrl_model ctl (.clk(clk), .sda_in(sda), .scl_o(scl), .sda_o(ctl_sda));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse counters and the hang limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (write_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
        end
        if (general_reset === 1'b1) begin
            n_greset <= n_greset + 1;
        end
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // Send a byte; e is the ack level expected (0 = acknowledged)
    task automatic put(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic       a;
        ctl.xfer(b, 1'b1, r, a);
        chk("ack", {7'h0, a}, {7'h0, e});
    endtask : put

    // Receive a byte; nack releases the ninth slot
    task automatic get(input logic nack, input logic [7:0] e);
        logic [7:0] r;
        logic       a;
        ctl.xfer(8'hFF, nack, r, a);
        chk("rdata", r, e);
    endtask : get

    initial begin
        logic [7:0] r;
        resetn = 1'b0;
        read_data = 8'h3C;
        {n_fail, compares, n_strobe, n_greset, cycles} = '0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        chk("sel", {6'h0, register_select_bits}, 8'h00);
        // Own write: address, pointer, data
        ctl.start();
        put(OWN_W, 1'b0);
        put(8'h01, 1'b0);
        put(8'hA5, 1'b0);
        ctl.stop();
        chk("wdata", write_data, 8'hA5);
        chk("sel", {6'h0, register_select_bits}, 8'h01);
        chk("strobes", 8'(n_strobe), 8'h01);
        // Pointer-only write, repeated START, read with NACK
        ctl.start();
        put(OWN_W, 1'b0);
        put(8'h02, 1'b0);
        ctl.start();
        put(OWN_R, 1'b0);
        get(1'b1, 8'h3C);
        ctl.stop();
        read_data = 8'hC3;
        ctl.start();
        put(OWN_R, 1'b0);
        get(1'b1, 8'hC3);
        ctl.stop();
        chk("sel", {6'h0, register_select_bits}, 8'h02);
        // Every variant address and a foreign one
        for (int i = 0; i < 8; i++) begin
            ctl.start();
            put({twbr_pkg::OWN_ADDR_BASE + 7'(i), 1'b0}, i != VAR);
            ctl.stop();
        end
        ctl.start();
        put(8'h90, 1'b1);
        ctl.stop();
        // Broadcast write then broadcast reads
        ctl.start();
        put(twbr_pkg::BCAST_WR_BYTE, 1'b0);
        put(8'h03, 1'b0);
        put(8'h5A, 1'b0);
        ctl.stop();
        chk("wdata", write_data, 8'h5A);
        read_data = 8'h96;
        ctl.start();
        put(twbr_pkg::BCAST_RD_BYTE, 1'b0);
        for (int s = 0; s < 4; s++) begin
            get(1'b0, (s == VAR) ? 8'h96 : 8'hFF);
        end
        ctl.stop();
        ctl.start();
        put(twbr_pkg::BCAST_RD_BYTE, 1'b0);
        for (int s = 0; s < 3; s++) begin
            get(s == 0, 8'hFF);
        end
        ctl.stop();
        // General call reset
        ctl.start();
        put(8'h00, 1'b0);
        put(twbr_pkg::GCALL_RESET_CMD, 1'b0);
        ctl.stop();
        chk("sel", {6'h0, register_select_bits}, 8'h00);
        chk("gresets", 8'(n_greset), 8'h01);
        // High-speed master code, restart, STOP
        ctl.start();
        put(8'h09, 1'b1);
        chk("hs", {7'h0, hs_filter}, 8'h01);
        ctl.start();
        put(OWN_W, 1'b0);
        put(8'h01, 1'b0);
        chk("hs", {7'h0, hs_filter}, 8'h01);
        ctl.stop();
        chk("hs", {7'h0, hs_filter}, 8'h00);
        // SCL parked low during the address ack, then recovery
        ctl.start();
        for (int i = 7; i >= 0; i--) begin
            ctl.bit_x(OWN_W[i], r[0]);
        end
        repeat (4) @(negedge clk);
        chk("oe_n", {7'h0, sda_oe_n}, 8'h00);
        repeat (TMO + 40) @(negedge clk);
        chk("oe_n", {7'h0, sda_oe_n}, 8'h01);
        ctl.stop();
        ctl.start();
        put(OWN_W, 1'b0);
        put(8'h01, 1'b0);
        put(8'h3F, 1'b0);
        ctl.stop();
        chk("wdata", write_data, 8'h3F);
        chk("strobes", 8'(n_strobe), 8'h03);
        // Mid-run reset clears the pointer; a write to the read-only slot changes nothing
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        chk("sel", {6'h0, register_select_bits}, 8'h00);
        ctl.start();
        put(OWN_W, 1'b0);
        put(8'h00, 1'b0);
        put(8'h11, 1'b0);
        ctl.stop();
        chk("wdata", write_data, 8'h00);
        chk("strobes", 8'(n_strobe), 8'h03);
        end_sim();
    end
endmodule : twbr_target_test
